// ===== verilog/mscs_motor_start_select.sv
// Start-up decision logic for a sensorless three-phase motor driver
`include "mscs_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module mscs_motor_start_select #(
  parameter int unsigned SPEED_DET_CYC = `MSCS_SPEED_DET_CYC,
  parameter int unsigned BRAKE_UNIT_CYC = `MSCS_BRAKE_UNIT_CYC
) (
  // Clock, reset, enable
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        clk_en_in,
  // Configuration
  input  wire logic [6:0]  motor_velocity_constant_in,
  input  wire logic        initial_speed_detect_en_in,
  input  wire logic        resync_en_in,
  input  wire logic        reverse_drive_en_in,
  input  wire logic        initial_position_detect_en_in,
  input  wire logic [2:0]  brake_duration_setting_in,
  input  wire logic [1:0]  reverse_drive_speed_limit_in,
  // Start request and motor sensing
  input  wire logic        start_in,
  input  wire logic        cmp_uv_in,
  input  wire logic        cmp_uw_in,
  input  wire logic        spin_forward_in,
  input  wire logic [1:0]  spin_speed_level_in,
  input  wire logic        speed_ok_in,
  input  wire logic        zero_speed_in,
  input  wire logic        pos_detect_done_in,
  input  wire logic        align_done_in,
  input  wire logic        closed_loop_ready_in,
  // Decoded constant, state and drive
  output logic [20:0]      velocity_const_uv_out,
  output logic [3:0]       start_state_out,
  output logic [5:0]       gate_pattern_out,
  output logic             gate_drive_en_out,
  output logic             stationary_out
);
  mscs_pkg::mscs_state_t state_q, state_d;
  logic [`MSCS_CNT_W-1:0] cnt_q, cnt_d;
  logic uv_q, uw_q, uv_d, uw_d;
  logic stat_q, stat_d;
  logic [5:0] pat_q, pat_d;
  logic en_q, en_d;
  logic [20:0] kt_q, kt_d;
  logic [2:0] kshift;
  logic [3:0] kmant;
  logic [10:0] kdig;
  logic toggled;
  logic [`MSCS_CNT_W-1:0] brake_cyc;

  assign kshift = motor_velocity_constant_in[`MSCS_KT_SHIFT_LSB +:
                                             `MSCS_KT_SHIFT_W];
  assign kmant  = motor_velocity_constant_in[`MSCS_KT_MANT_W-1:0];
  // Any shift with any mantissa decodes alike, listed or not
  assign kdig   = 11'(kmant) << kshift;
  // History tracks in IDLE too, so DETECT never opens on a false edge
  assign toggled = (cmp_uv_in != uv_q) || (cmp_uw_in != uw_q);
  // Counter width covers seven units of the default brake time
  assign brake_cyc = `MSCS_CNT_W'(BRAKE_UNIT_CYC) *
                     `MSCS_CNT_W'(brake_duration_setting_in);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    uv_d    = cmp_uv_in;
    uw_d    = cmp_uw_in;
    stat_d  = stat_q;
    pat_d   = 6'h00;
    en_d    = 1'b0;
    kt_d    = 21'(kdig) * 21'(`MSCS_KT_UV_PER_LSB);
    case (state_q)
      mscs_pkg::MSCS_IDLE: begin
        cnt_d = '0;
        if (start_in) begin
          if (initial_speed_detect_en_in) begin
            // Fresh verdict each start; an old one must not leak
            stat_d  = 1'b0;
            state_d = mscs_pkg::MSCS_DETECT;
          end else begin
            stat_d  = 1'b1;
            state_d = mscs_pkg::MSCS_COAST;
          end
        end
      end
      mscs_pkg::MSCS_DETECT: begin
        // Window restarts on each edge, so only true silence counts
        if (toggled) begin
          cnt_d = '0;
          if (spin_forward_in) begin
            if (resync_en_in && speed_ok_in) begin
              state_d = mscs_pkg::MSCS_CLOSED;
            end
          end else begin
            stat_d  = 1'b0;
            state_d = mscs_pkg::MSCS_REV_WAIT;
          end
        end else if (cnt_q >= `MSCS_CNT_W'(SPEED_DET_CYC - 1)) begin
          stat_d  = 1'b1;
          cnt_d   = '0;
          state_d = mscs_pkg::MSCS_BRAKE;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      mscs_pkg::MSCS_REV_WAIT: begin
        // Too fast to reverse drive or brake safely: keep coasting
        if (spin_speed_level_in <= reverse_drive_speed_limit_in) begin
          state_d = reverse_drive_en_in ? mscs_pkg::MSCS_REV_DRIVE
                                        : mscs_pkg::MSCS_COAST;
        end
      end
      mscs_pkg::MSCS_REV_DRIVE: begin
        en_d = 1'b1;
        if (zero_speed_in) begin
          state_d = mscs_pkg::MSCS_ACCEL;
        end
      end
      mscs_pkg::MSCS_COAST: begin
        cnt_d = '0;
        if (brake_duration_setting_in != 3'h0) begin
          state_d = mscs_pkg::MSCS_BRAKE;
        end else if (stat_q || zero_speed_in) begin
          // Brake disabled: rotor must come to rest on its own
          state_d = mscs_pkg::MSCS_BRAKE;
        end
      end
      mscs_pkg::MSCS_BRAKE: begin
        if ((brake_duration_setting_in != 3'h0) &&
            (cnt_q < brake_cyc)) begin
          pat_d = `MSCS_BRAKE_PATTERN;
          en_d  = 1'b1;
          cnt_d = cnt_q + 1'b1;
        end else begin
          cnt_d   = '0;
          stat_d  = 1'b1;
          // Position is unknown after a stop, so re-phase first
          state_d = initial_position_detect_en_in ?
                    mscs_pkg::MSCS_POS_DETECT : mscs_pkg::MSCS_ALIGN;
        end
      end
      mscs_pkg::MSCS_POS_DETECT: begin
        // Rotor stays still; probing pulses come from the sensing block
        if (pos_detect_done_in) begin
          state_d = mscs_pkg::MSCS_ACCEL;
        end
      end
      mscs_pkg::MSCS_ALIGN: begin
        pat_d = `MSCS_ALIGN_PATTERN;
        en_d  = 1'b1;
        if (align_done_in) begin
          state_d = mscs_pkg::MSCS_ACCEL;
        end
      end
      mscs_pkg::MSCS_ACCEL: begin
        // The acceleration profile itself lives in the drive block
        en_d = 1'b1;
        if (closed_loop_ready_in) begin
          state_d = mscs_pkg::MSCS_CLOSED;
        end
      end
      mscs_pkg::MSCS_CLOSED: begin
        en_d = 1'b1;
        if (!start_in) begin
          state_d = mscs_pkg::MSCS_IDLE;
        end
      end
      default: begin
        state_d = mscs_pkg::MSCS_IDLE;
      end
    endcase
    if (!start_in) begin
      state_d = mscs_pkg::MSCS_IDLE;
      en_d    = 1'b0;
      pat_d   = 6'h00;
    end
  end

  // Clock enable low holds every register, outputs included
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state_q <= mscs_pkg::MSCS_IDLE;
      cnt_q   <= '0;
      uv_q    <= 1'b0;
      uw_q    <= 1'b0;
      stat_q  <= 1'b0;
      pat_q   <= 6'h00;
      en_q    <= 1'b0;
      kt_q    <= '0;
    end else if (clk_en_in) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      uv_q    <= uv_d;
      uw_q    <= uw_d;
      stat_q  <= stat_d;
      pat_q   <= pat_d;
      en_q    <= en_d;
      kt_q    <= kt_d;
    end
  end

  assign velocity_const_uv_out = kt_q;
  assign start_state_out       = 4'(state_q);
  assign gate_pattern_out      = pat_q;
  assign gate_drive_en_out     = en_q;
  assign stationary_out        = stat_q;
endmodule // mscs_motor_start_select
`default_nettype wire

// ===== verilog/mscs_consts.svh
// Constants for the motor start condition selector
`ifndef MSCS_CONSTS_SVH
`define MSCS_CONSTS_SVH
`define MSCS_KT_SHIFT_LSB     4
`define MSCS_KT_SHIFT_W       3
`define MSCS_KT_MANT_W        4
`define MSCS_KT_DIG_W         11
`define MSCS_KT_UV_PER_LSB    920
`define MSCS_KT_UV_W          21
`define MSCS_CLK_HZ           10000000
`define MSCS_BRAKE_UNIT_MS    100
`define MSCS_BRAKE_UNIT_CYC   ((`MSCS_CLK_HZ / 1000) * `MSCS_BRAKE_UNIT_MS)
`define MSCS_SPEED_DET_MS     10
`define MSCS_SPEED_DET_CYC    ((`MSCS_CLK_HZ / 1000) * `MSCS_SPEED_DET_MS)
`define MSCS_CNT_W            24
`define MSCS_ALIGN_PATTERN    6'h18
`define MSCS_BRAKE_PATTERN    6'h07
`endif

// ===== verilog/mscs_pkg.sv
// Types for the motor start condition selector
`default_nettype none
package mscs_pkg;
  typedef enum logic [3:0] {
    MSCS_IDLE,
    MSCS_DETECT,
    MSCS_REV_WAIT,
    MSCS_REV_DRIVE,
    MSCS_COAST,
    MSCS_BRAKE,
    MSCS_POS_DETECT,
    MSCS_ALIGN,
    MSCS_ACCEL,
    MSCS_CLOSED
  } mscs_state_t;
endpackage
`default_nettype wire

// ===== tb/mscs_motor_start_select_asserts.sv
// Port assertions for the motor start selector
`timescale 1ns/100ps
`default_nettype none
module mscs_start_checker (
  // Clock, control and sensing
  input wire logic        mclk_in, sys_rst_in, clk_en_in, start_in,
  input wire logic        reverse_drive_en_in, resync_en_in, speed_ok_in,
  input wire logic        spin_forward_in,
  input wire logic [6:0]  motor_velocity_constant_in,
  input wire logic [1:0]  spin_speed_level_in, reverse_drive_speed_limit_in,
  // Outputs watched
  input wire logic [20:0] velocity_const_uv_out,
  input wire logic [3:0]  start_state_out,
  input wire logic [5:0]  gate_pattern_out,
  input wire logic        gate_drive_en_out, stationary_out
);
  wire [3:0] s = start_state_out;
  wire [6:0] k = motor_velocity_constant_in;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  kt_decode_a: assert property (!$past(sys_rst_in) && $past(clk_en_in)
    |-> velocity_const_uv_out == ({17'h0, $past(k[3:0])} << $past(k[6:4]))
    * 21'h398) else $error("velocity decode wrong");
  brake_gates_a: assert property (s == 4'h5 && gate_drive_en_out |->
    gate_pattern_out == 6'h07) else $error("brake pattern wrong");
  align_gates_a: assert property (!$past(sys_rst_in) &&
    $past(clk_en_in) && $past(start_in) && $past(s) == 4'h7 |->
    gate_drive_en_out && gate_pattern_out == 6'h18)
    else $error("align drive wrong");
  idle_off_a: assert property (s == 4'h0 |-> !gate_drive_en_out &&
    gate_pattern_out == 6'h00) else $error("idle drive on");
  resync_path_a: assert property ($past(s) == 4'h1 && s == 4'h9 |->
    $past(resync_en_in && speed_ok_in && spin_forward_in))
    else $error("resync without cause");
  quiet_stat_a: assert property ($past(s) == 4'h1 && s == 4'h5 |->
    stationary_out) else $error("stationary flag missing");
  rev_limit_a: assert property ($past(s) == 4'h2 && s == 4'h3 |->
    $past(spin_speed_level_in <= reverse_drive_speed_limit_in))
    else $error("reverse drive too fast");
  rev_off_a: assert property ($past(s) == 4'h2 && s == 4'h4 |->
    !$past(reverse_drive_en_in)) else $error("coast with reverse drive");
  start_abort_a: assert property (!start_in && clk_en_in |=> s == 4'h0)
    else $error("abort did not idle");
  cover property (s == 4'h9);
  cover property (s == 4'h3);
  cover property (s == 4'h5 && gate_drive_en_out);
endmodule // mscs_start_checker
bind mscs_motor_start_select mscs_start_checker chk_i (.*);
`default_nettype wire

// ===== tb/mscs_motor_model.sv
// Behavioural motor windings seen through the phase comparators
`timescale 1ns/100ps
`default_nettype none
module mscs_motor_model (
  input  wire logic       mclk_in,
  input  wire logic [1:0] spin_in,
  output logic            cmp_uv_out,
  output logic            cmp_uw_out,
  output logic            forward_out,
  output logic            stopped_out
);
  logic [2:0] ph_q = 3'h0;
  // A still rotor makes no back-EMF, so the comparators freeze
  always @(posedge mclk_in) if (spin_in != 2'h0) ph_q <= ph_q + 3'h1;
  assign cmp_uv_out = ph_q[2];
  assign cmp_uw_out = ph_q[2] ^ ph_q[1];
  assign forward_out = spin_in == 2'h1;
  assign stopped_out = spin_in == 2'h0;
endmodule // mscs_motor_model
`default_nettype wire

// ===== tb/test_mscs_motor_start_select.sv
// Self-checking bench for the motor start selector
`timescale 1ns/100ps
`default_nettype none
module test_mscs_motor_start_select;
  logic clk = 0, rst = 1, en = 1, initial_speed_detect = 1, rsy = 0, rev = 0, initial_position_detect = 0;
  logic start = 0, ok = 0, pd = 0, ad = 0, cl = 0, cu, cw, fw, zs, ge, stn;
  logic [6:0] kt = 7'h00;
  logic [2:0] brk = 3'h0;
  logic [1:0] lim = 2'h1, lvl = 2'h0, mode = 2'h0;
  logic [20:0] uv;
  logic [3:0] st;
  logic [5:0] gp;
  int mismatches = 0, checks_done = 0, n, t = 0;
  initial forever #50 clk = ~clk;
  mscs_motor_model motor (.mclk_in(clk), .spin_in(mode), .cmp_uv_out(cu),
    .cmp_uw_out(cw), .forward_out(fw), .stopped_out(zs));
  mscs_motor_start_select #(.SPEED_DET_CYC(8), .BRAKE_UNIT_CYC(4)) uut (
    .mclk_in(clk), .sys_rst_in(rst), .clk_en_in(en),
    .motor_velocity_constant_in(kt), .initial_speed_detect_en_in(initial_speed_detect),
    .resync_en_in(rsy), .reverse_drive_en_in(rev),
    .initial_position_detect_en_in(initial_position_detect), .brake_duration_setting_in(brk),
    .reverse_drive_speed_limit_in(lim), .start_in(start), .cmp_uv_in(cu),
    .cmp_uw_in(cw), .spin_forward_in(fw), .spin_speed_level_in(lvl),
    .speed_ok_in(ok), .zero_speed_in(zs), .pos_detect_done_in(pd),
    .align_done_in(ad), .closed_loop_ready_in(cl),
    .velocity_const_uv_out(uv), .start_state_out(st),
    .gate_pattern_out(gp), .gate_drive_en_out(ge), .stationary_out(stn));
  task automatic chk(string nm, logic [20:0] e, logic [20:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wait_st(logic [3:0] e);
    n = 0;
    while (st !== e && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("state", e, st);
  endtask
  // Positioning, acceleration and closed loop; a resync start (4'h9) goes straight to closed loop
  task automatic finish_start(logic [3:0] p);
    wait_st(p);
    // Drive outputs trail the state register by one clock
    @(negedge clk);
    if (p == 4'h7) chk("align", 21'h18, gp);
    {pd, ad, mode} = 4'hC;
    if (p != 4'h9) begin
      wait_st(4'h8);
      @(negedge clk);
      chk("accel drive", 21'h1, ge);
      cl = 1;
    end
    wait_st(4'h9);
    @(negedge clk);
    chk("drive", 21'h1, ge);
    start = 0;
    {pd, ad, cl, ok, rsy} = 5'h00;
    wait_st(4'h0);
    t++;
    $display("test %0d done", t);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst = 0;
    for (int i = 0; i < 128; i++) begin
      kt = 7'(i);
      @(negedge clk);
      chk("kt", ({17'h0, kt[3:0]} << kt[6:4]) * 21'h398, uv);
    end
    $display("test decode done");
    start = 1;
    wait_st(4'h5);
    chk("still", 21'h1, stn);
    finish_start(4'h7);
    {brk, initial_position_detect, start} = 5'hB;
    wait_st(4'h5);
    @(negedge clk);
    chk("brake", 21'h07, gp);
    wait_st(4'h6);
    chk("brake time", 21'h8, 21'(n));
    finish_start(4'h6);
    {mode, rsy, ok, start} = 5'hF;
    finish_start(4'h9);
    chk("moving", 21'h0, stn);
    {mode, rev, lvl, initial_position_detect, start} = 7'h5D;
    wait_st(4'h2);
    repeat (20) @(negedge clk);
    chk("rev hold", 21'h2, st);
    rst = 1;
    @(negedge clk);
    rst = 0;
    chk("reset", 21'h0, 21'({st, ge, stn}));
    wait_st(4'h2);
    lvl = 2'h1;
    finish_start(4'h3);
    {mode, rev, lvl, brk, start} = 9'h103;
    wait_st(4'h4);
    wait_st(4'h5);
    finish_start(4'h7);
    {mode, rev, lvl, brk, start} = 9'h101;
    wait_st(4'h4);
    repeat (20) @(negedge clk);
    chk("coast hold", 21'h4, st);
    {en, mode} = 3'h0;
    repeat (5) @(negedge clk);
    chk("frozen", 21'h4, st);
    en = 1;
    finish_start(4'h7);
    results;
  end
  initial begin
    #5000000;
    mismatches++;
    results;
  end
endmodule // test_mscs_motor_start_select
`default_nettype wire
